// file: src/mono_audio_pwm_engine.sv
`timescale 1ns/1ns
`include "audio_map.svh"
// Overview of operation
// - Mono audio leaves as PWM on one pin
// - Output mixes synthesizer and RAM sample playback
// - Code then trigger write of 1 starts effect
// - Effect trigger reads 1 while sounding
// - Looping effects run until replaced by retrigger
// - Code zero plus trigger gives silence
// - Synth volume register scales effect loudness
// - Effect code 16 bits, low byte selects
// - Upper byte is MIDI note, zero middle C
// - Fixed-pitch effects ignore the upper byte
// - Playback reads RAM from start for length
// - Samples consumed at programmed rate in hertz
// - Linear, mu-law and ADPCM formats decoded
// - ADPCM low nibble first, high nibble second
// - Any write to playback trigger starts playback if length is nonzero
// - Playback trigger reads 1 while playing
// - Playback volume 0 to 255 scales samples
// - Read pointer register shows fetch address
module mono_audio_pwm_engine
    import audio_pkg::*;
#(
    parameter int SHOT_CYCLES = `SHOT_TIME_MS * (`CLK_HZ / 1000)
) (
    input  wire logic               clk_in,
    input  wire logic               sys_rst_in,
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [7:0]         paddr_in,
    input  wire logic [31:0]        pwdata_in,
    output logic      [31:0]        prdata_out,
    output logic                    pready_out,
    output logic                    pslverr_out,
    output logic                    ram_rd_out,
    output logic      [`RAM_AW-1:0] ram_addr_out,
    input  wire logic [7:0]         ram_data_in,
    output logic                    audio_pwm_out
);

    // ======================================================================
    // Constant tables
    localparam logic [31:0] SEMI_INC [0:11] = '{32'h00002BE5, 32'h00002E81, 32'h00003145,
        32'h00003433, 32'h0000374D, 32'h00003A97, 32'h00003E13, 32'h000041C4,
        32'h000045AD, 32'h000049D2, 32'h00004E36, 32'h000052DC};
    localparam logic [14:0] STEP_TAB [0:88] = '{15'd7, 15'd8, 15'd9, 15'd10, 15'd11, 15'd12,
        15'd13, 15'd14, 15'd16, 15'd17, 15'd19, 15'd21, 15'd23, 15'd25, 15'd28, 15'd31, 15'd34,
        15'd37, 15'd41, 15'd45, 15'd50, 15'd55, 15'd60, 15'd66, 15'd73, 15'd80, 15'd88, 15'd97,
        15'd107, 15'd118, 15'd130, 15'd143, 15'd157, 15'd173, 15'd190, 15'd209, 15'd230, 15'd253,
        15'd279, 15'd307, 15'd337, 15'd371, 15'd408, 15'd449, 15'd494, 15'd544, 15'd598, 15'd658,
        15'd724, 15'd796, 15'd876, 15'd963, 15'd1060, 15'd1166, 15'd1282, 15'd1411, 15'd1552,
        15'd1707, 15'd1878, 15'd2066, 15'd2272, 15'd2499, 15'd2749, 15'd3024, 15'd3327, 15'd3660,
        15'd4026, 15'd4428, 15'd4871, 15'd5358, 15'd5894, 15'd6484, 15'd7132, 15'd7845, 15'd8630,
        15'd9493, 15'd10442, 15'd11487, 15'd12635, 15'd13899, 15'd15289, 15'd16818, 15'd18500,
        15'd20350, 15'd22385, 15'd24623, 15'd27086, 15'd29794, 15'd32767};
    localparam logic [26:0] CLK_HZ_C = 27'(`CLK_HZ);

    // ======================================================================
    // Registers and state
    logic [15:0]         effect_code_reg;
    logic [15:0]         active_code;
    logic                fx_playing;
    logic [7:0]          synth_volume;
    logic [`RAM_AW-1:0]  pb_start;
    logic [`RAM_AW-1:0]  pb_length;
    logic [`RATE_W-1:0]  pb_sample_rate;
    pb_format_e          pb_format;
    logic                pb_repeat;
    logic [7:0]          pb_volume;
    logic                pb_playing;
    pb_state_e           pb_state;
    logic [`RAM_AW-1:0]  pb_read_pointer;
    logic [`RAM_AW-1:0]  pb_remain;
    logic [7:0]          pb_byte;
    logic                nib_sel;
    logic [26:0]         rate_acc;
    logic signed [15:0]  pb_sample;
    logic signed [15:0]  adpcm_pred;
    logic [6:0]          adpcm_idx;
    logic [31:0]         shot_cnt;
    logic [31:0]         phase;
    logic [`PWM_W-1:0]   pwm_cnt;
    logic [`PWM_W-1:0]   pwm_duty;

    // ======================================================================
    // APB decode
    wire setup_phase = psel_in && !penable_in;
    wire wr_fire     = psel_in && penable_in && pready_out && pwrite_in;
    wire hit_code    = paddr_in == `OFS_EFFECT_CODE;
    wire hit_fxtrig  = paddr_in == `OFS_EFFECT_TRIGGER;
    wire hit_svol    = paddr_in == `OFS_SYNTH_VOLUME;
    wire hit_start   = paddr_in == `OFS_PB_START;
    wire hit_len     = paddr_in == `OFS_PB_LENGTH;
    wire hit_rate    = paddr_in == `OFS_PB_SAMPLE_RATE;
    wire hit_fmt     = paddr_in == `OFS_PB_FORMAT;
    wire hit_rep     = paddr_in == `OFS_PB_REPEAT;
    wire hit_pbtrig  = paddr_in == `OFS_PB_TRIGGER;
    wire hit_pvol    = paddr_in == `OFS_PB_VOLUME;
    wire hit_ptr     = paddr_in == `OFS_PB_READ_POINTER;
    wire hit_any     = hit_code | hit_fxtrig | hit_svol | hit_start | hit_len | hit_rate
                     | hit_fmt | hit_rep | hit_pbtrig | hit_pvol | hit_ptr;
    wire fx_trig_wr  = wr_fire && hit_fxtrig && pwdata_in[0];
    wire pb_trig_wr  = wr_fire && hit_pbtrig;

    // Read mux; unmapped addresses read zero and flag an error
    logic [31:0] rd_mux;
    always_comb begin
        if (hit_code) rd_mux = {16'h0000, effect_code_reg};
        else if (hit_fxtrig) rd_mux = {31'h0, fx_playing};
        else if (hit_svol) rd_mux = {24'h0, synth_volume};
        else if (hit_start) rd_mux = {12'h0, pb_start};
        else if (hit_len) rd_mux = {12'h0, pb_length};
        else if (hit_rate) rd_mux = {16'h0, pb_sample_rate};
        else if (hit_fmt) rd_mux = {30'h0, pb_format};
        else if (hit_rep) rd_mux = {31'h0, pb_repeat};
        else if (hit_pbtrig) rd_mux = {31'h0, pb_playing};
        else if (hit_pvol) rd_mux = {24'h0, pb_volume};
        else if (hit_ptr) rd_mux = {12'h0, pb_read_pointer};
        else rd_mux = 32'h0;
    end

    // No wait state: pready is high in the first access cycle, and every bus output comes straight from a flop
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else begin
            pready_out  <= setup_phase;
            pslverr_out <= setup_phase && !hit_any;
            prdata_out  <= setup_phase && !pwrite_in ? rd_mux : 32'h0;
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            effect_code_reg <= 16'h0;
            synth_volume    <= `RST_SYNTH_VOLUME;
            pb_start        <= '0;
            pb_length       <= '0;
            pb_sample_rate  <= `RST_PB_RATE;
            pb_format       <= fmt_linear;
            pb_repeat       <= 1'b0;
            pb_volume       <= `RST_PB_VOLUME;
        end else if (wr_fire) begin
            if (hit_code) effect_code_reg <= pwdata_in[15:0];
            if (hit_svol) synth_volume <= pwdata_in[7:0];
            if (hit_start) pb_start <= pwdata_in[`RAM_AW-1:0];
            if (hit_len) pb_length <= pwdata_in[`RAM_AW-1:0];
            if (hit_rate) pb_sample_rate <= pwdata_in[`RATE_W-1:0];
            if (hit_fmt && pwdata_in[1:0] != 2'b11) pb_format <= pb_format_e'(pwdata_in[1:0]);
            if (hit_rep) pb_repeat <= pwdata_in[0];
            if (hit_pvol) pb_volume <= pwdata_in[7:0];
        end
    end

    // ======================================================================
    // Sound synthesizer: codes 1-3 loop with pitch, 10h-13h are fixed beeps
    wire [7:0] new_lo   = effect_code_reg[`CODE_LO_MSB:0];
    wire       new_live = (new_lo >= 8'h01 && new_lo <= 8'h03) || (new_lo >= 8'h10 && new_lo <= 8'h13);
    wire [7:0] act_lo   = active_code[`CODE_LO_MSB:0];
    wire       fx_shot  = act_lo[4];
    wire [7:0] note     = fx_shot ? `SHOT_NOTE : active_code[15:`CODE_HI_LSB];
    wire [7:0] oct_raw  = note / 8'd12;
    wire [3:0] semi     = 4'(note % 8'd12);
    wire [2:0] octave   = oct_raw > 8'd7 ? 3'd7 : oct_raw[2:0]; // Beyond 7 octaves would alias
    wire [31:0] phase_inc = SEMI_INC[semi] << octave; // Note zero gives middle C

    // Trigger, replace and end of effects; a new trigger beats the end
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            active_code <= 16'h0;
            fx_playing  <= 1'b0;
            shot_cnt    <= 32'h0;
        end else if (fx_trig_wr) begin
            active_code <= effect_code_reg;
            fx_playing  <= new_live;
            shot_cnt    <= 32'(SHOT_CYCLES);
        end else if (fx_playing && fx_shot) begin
            shot_cnt   <= shot_cnt - 32'h1;
            fx_playing <= shot_cnt != 32'h1;
        end
    end

    // Phase accumulator oscillator
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) phase <= 32'h0;
        else if (fx_trig_wr) phase <= 32'h0;
        else phase <= phase + phase_inc;
    end

    // Wave shapes: square, saw, triangle
    wire [7:0] tri_u  = phase[31] ? ~phase[30:23] : phase[30:23];
    wire [7:0] wave_u = act_lo[1:0] == 2'd1 ? {8{phase[31]}} : act_lo[1:0] == 2'd2 ? phase[31:24] : tri_u;
    wire signed [7:0]  wave_s      = fx_playing ? signed'(wave_u ^ 8'h80) : 8'sh00;
    wire signed [16:0] synth_prod  = wave_s * signed'({1'b0, synth_volume});
    wire signed [15:0] synth_scaled = synth_prod[15:0];

    // ======================================================================
    // Playback sample clock: fractional accumulator against the core clock
    wire [26:0] acc_sum     = rate_acc + 27'(pb_sample_rate);
    wire        sample_tick = pb_playing && acc_sum >= CLK_HZ_C;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) rate_acc <= 27'h0;
        else if (pb_trig_wr || !pb_playing) rate_acc <= 27'h0;
        else rate_acc <= sample_tick ? acc_sum - CLK_HZ_C : acc_sum;
    end

    // Mu-law expansion
    wire [7:0]  mu_inv  = ~pb_byte;
    wire [14:0] mu_mag  = 15'(({mu_inv[3:0], 3'b000} + 8'h84) << mu_inv[6:4]) - 15'h0084;
    wire signed [15:0] mu_s = mu_inv[7] ? -signed'({1'b0, mu_mag}) : signed'({1'b0, mu_mag});

    // IMA ADPCM step for the current nibble
    wire [3:0]  nib  = nib_sel ? pb_byte[7:4] : pb_byte[3:0];
    logic [14:0] step;
    logic [16:0] diff;
    logic signed [17:0] pred_sum;
    logic signed [15:0] next_pred;
    logic signed [8:0]  idx_sum;
    logic [6:0] next_idx;
    always_comb begin
        step = STEP_TAB[adpcm_idx];
        diff = 17'(step >> 3);
        if (nib[2]) diff = diff + 17'(step);
        if (nib[1]) diff = diff + 17'(step >> 1);
        if (nib[0]) diff = diff + 17'(step >> 2);
        pred_sum = nib[3] ? 18'(adpcm_pred) - signed'({1'b0, diff}) : 18'(adpcm_pred) + signed'({1'b0, diff});
        if (pred_sum > 18'sd32767) next_pred = 16'sh7FFF;
        else if (pred_sum < -18'sd32768) next_pred = 16'sh8000;
        else next_pred = pred_sum[15:0];
        idx_sum = 9'(adpcm_idx) + (nib[2] ? 9'(2 * nib[1:0] + 2) : -9'sd1);
        if (idx_sum < 0) next_idx = 7'd0;
        else if (idx_sum > 9'sd88) next_idx = 7'd88;
        else next_idx = idx_sum[6:0];
    end

    // Decoded sample per format
    wire signed [15:0] dec_sample = pb_format == fmt_adpcm ? next_pred :
                                    pb_format == fmt_mu_law ? mu_s : {pb_byte, 8'h00};
    wire byte_done = pb_format != fmt_adpcm || nib_sel;
    wire last_byte = pb_remain == `RAM_AW'(1);

    // Playback sequencer; a trigger write restarts from any state
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pb_state        <= PB_IDLE;
            pb_playing      <= 1'b0;
            pb_read_pointer <= '0;
            pb_remain       <= '0;
            pb_byte         <= 8'h0;
            nib_sel         <= 1'b0;
            pb_sample       <= 16'sh0;
            adpcm_pred      <= 16'sh0;
            adpcm_idx       <= 7'd0;
            ram_rd_out      <= 1'b0;
            ram_addr_out    <= '0;
        end else if (pb_trig_wr) begin
            pb_read_pointer <= pb_start;
            pb_remain       <= pb_length;
            pb_playing      <= pb_length != '0;
            pb_state        <= pb_length != '0 ? PB_FETCH : PB_IDLE;
            nib_sel         <= 1'b0;
            adpcm_pred      <= 16'sh0;
            adpcm_idx       <= 7'd0;
            ram_rd_out      <= 1'b0;
        end else begin
            ram_rd_out <= 1'b0;
            case (pb_state)
                PB_FETCH: begin
                    ram_rd_out   <= 1'b1;
                    ram_addr_out <= pb_read_pointer;
                    pb_state     <= PB_WAIT;
                end
                PB_WAIT: begin
                    if (!ram_rd_out) begin // RAM answers one cycle after the request
                        pb_byte  <= ram_data_in;
                        pb_state <= PB_HOLD;
                    end
                end
                PB_HOLD: begin
                    if (sample_tick) begin
                        pb_sample <= dec_sample;
                        if (pb_format == fmt_adpcm) begin
                            adpcm_pred <= next_pred;
                            adpcm_idx  <= next_idx;
                        end
                        nib_sel <= !byte_done;
                        if (byte_done && last_byte && pb_repeat) begin
                            pb_read_pointer <= pb_start;
                            pb_remain       <= pb_length;
                            pb_state        <= PB_FETCH;
                        end else if (byte_done && last_byte) begin
                            pb_playing <= 1'b0;
                            pb_state   <= PB_IDLE;
                        end else if (byte_done) begin
                            pb_read_pointer <= pb_read_pointer + `RAM_AW'(1);
                            pb_remain       <= pb_remain - `RAM_AW'(1);
                            pb_state        <= PB_FETCH;
                        end
                    end
                end
                default: begin
                    pb_state <= PB_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Mixer and PWM; silence once playback ends avoids a stuck DC level
    wire signed [15:0] pb_src    = pb_playing ? pb_sample : 16'sh0;
    wire signed [24:0] pb_prod   = pb_src * signed'({1'b0, pb_volume});
    wire signed [16:0] mix_sum   = 17'(synth_scaled) + 17'(signed'(pb_prod[23:8]));
    wire signed [15:0] mix_clip  = mix_sum > 17'sd32767 ? 16'sh7FFF :
                                   mix_sum < -17'sd32768 ? 16'sh8000 : mix_sum[15:0];
    wire [`PWM_W-1:0]  mix_duty  = mix_clip[15:6] ^ `PWM_W'(512);

    // Duty is taken only at the period start so each pulse is whole
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pwm_cnt       <= '0;
            pwm_duty      <= `PWM_W'(512);
            audio_pwm_out <= 1'b0;
        end else begin
            pwm_cnt       <= pwm_cnt + `PWM_W'(1);
            if (pwm_cnt == '1) pwm_duty <= mix_duty;
            audio_pwm_out <= pwm_cnt < pwm_duty;
        end
    end

    // ======================================================================
    // Assertions
    AST_PWM_HIGH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pwm_cnt == '0 && pwm_duty != '0) |=> audio_pwm_out) else $error("pwm not high at period start");
    AST_PWM_LOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pwm_cnt == '1) |=> !audio_pwm_out) else $error("pwm high at period end");
    AST_FX_START: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (fx_trig_wr && new_lo == 8'h02) |=> fx_playing ##1 fx_playing) else $error("effect did not start");
    AST_FX_SILENCE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (fx_trig_wr && new_lo == 8'h00) |=> !fx_playing && wave_s == 8'sh00) else $error("silence failed");
    AST_FX_LOOP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (fx_playing && !fx_shot && !fx_trig_wr) |=> fx_playing) else $error("looping effect stopped");
    AST_FX_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (setup_phase && !pwrite_in && hit_fxtrig) |=> pready_out && prdata_out == {31'h0, $past(fx_playing)})
        else $error("effect trigger read wrong");
    AST_FIXED_PITCH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        fx_shot |-> phase_inc == SEMI_INC[0] << 1) else $error("fixed effect pitch moved");
    AST_PB_START: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pb_trig_wr && pb_length != '0) |=> pb_playing && pb_read_pointer == $past(pb_start) ##1 ram_rd_out)
        else $error("playback did not start");
    AST_PB_STOP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pb_state == PB_HOLD && sample_tick && byte_done && last_byte && !pb_repeat && !pb_trig_wr)
        |=> !pb_playing && pb_state == PB_IDLE) else $error("playback did not stop");
    AST_NIBBLE_ORDER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pb_state == PB_HOLD && sample_tick && pb_format == fmt_adpcm && !nib_sel && !pb_trig_wr)
        |=> nib_sel && pb_state == PB_HOLD && $stable(pb_read_pointer)) else $error("nibble order broken");

endmodule

// file: inc/audio_map.svh
`ifndef AUDIO_MAP_SVH
`define AUDIO_MAP_SVH

// ==========================================================================
// Register byte offsets
`define OFS_EFFECT_CODE     8'h00
`define OFS_EFFECT_TRIGGER  8'h04
`define OFS_SYNTH_VOLUME    8'h08
`define OFS_PB_START        8'h0C
`define OFS_PB_LENGTH       8'h10
`define OFS_PB_SAMPLE_RATE  8'h14
`define OFS_PB_FORMAT       8'h18
`define OFS_PB_REPEAT       8'h1C
`define OFS_PB_TRIGGER      8'h20
`define OFS_PB_VOLUME       8'h24
`define OFS_PB_READ_POINTER 8'h28

// ==========================================================================
// Field positions and widths
`define CODE_LO_MSB  7
`define CODE_HI_LSB  8
`define RAM_AW       20
`define RATE_W       16
`define PWM_W        10

// ==========================================================================
// Reset values
`define RST_SYNTH_VOLUME 8'hFF
`define RST_PB_VOLUME    8'hFF
`define RST_PB_RATE      16'h1F40

// ==========================================================================
// Timing
`define CLK_HZ       100000000
`define SHOT_TIME_MS 50
`define SHOT_NOTE    8'h0C

`endif

// file: inc/audio_pkg.sv
package audio_pkg;

    // Playback fetch sequencer, Gray coded along idle-fetch-wait-hold
    typedef enum logic [1:0] {
        PB_IDLE  = 2'b00,
        PB_FETCH = 2'b01,
        PB_WAIT  = 2'b11,
        PB_HOLD  = 2'b10
    } pb_state_e;

    // Playback sample encodings
    typedef enum logic [1:0] {
        fmt_linear = 2'b00,
        fmt_mu_law = 2'b01,
        fmt_adpcm  = 2'b10
    } pb_format_e;

endpackage

// file: sim/audio_filter_model.sv
`timescale 1ns/1ns
// ==========================================================================
// Output stage model
// Moving average over one PWM period stands in for the analog low-pass
// filter; a full-period window gives the duty whatever the phase.
module audio_filter_model (
    input  wire logic clk_in,
    input  wire logic audio_pwm_in,
    output int        level_out
);
    logic [1023:0] hist = '0;
    // Running sum of the last 1024 samples of the pin
    always @(posedge clk_in) begin
        level_out <= level_out + int'(audio_pwm_in) - int'(hist[1023]);
        hist <= {hist[1022:0], audio_pwm_in};
    end
endmodule

// file: sim/mono_audio_pwm_engine_tb.sv
`timescale 1ns/1ns
`include "audio_map.svh"
module mono_audio_pwm_engine_tb;
    import audio_pkg::*;
    logic               clk_in = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00, ram_data = 8'h00;
    logic [31:0]        pwdata = 32'h0, prdata_out;
    logic               pready_out, pslverr_out, ram_rd_out, audio_pwm_out;
    logic [`RAM_AW-1:0] ram_addr_out;
    int                 level, fails = 0, comparisons = 0, cyc = 0, last_rd = 0;
    int                 model [11];
    int                 msk [11] = '{32'hFFFF, 0, 32'hFF, 32'hFFFFF, 32'hFFFFF, 32'hFFFF, 3, 1, 0, 32'hFF, 0};
    int                 codes [7] = '{1, 2, 3, 16, 17, 18, 19};
    int                 exp_addr [$], gaps [$];

    mono_audio_pwm_engine #(.SHOT_CYCLES(20)) DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .ram_rd_out(ram_rd_out),
        .ram_addr_out(ram_addr_out), .ram_data_in(ram_data), .audio_pwm_out(audio_pwm_out));
    audio_filter_model FILT (.clk_in(clk_in), .audio_pwm_in(audio_pwm_out), .level_out(level));

    // ======================================================================
    // Clock, cycle count and RAM model
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) cyc <= cyc + 1;
    // Answers each fetch next cycle; otherwise the data toggles so stale bytes show
    always @(posedge clk_in) begin
        if (ram_rd_out === 1'b1) begin
            chk_ram(ram_addr_out, exp_addr.size() != 0 ? 20'(exp_addr.pop_front()) : 'x);
            gaps.push_back(cyc - last_rd);
            last_rd = cyc;
            ram_data <= 8'($urandom);
        end else ram_data <= ~ram_data;
    end

    // ======================================================================
    // Compare tasks and APB master
    task automatic bump(input logic ok, input string msg);
        comparisons++;
        if (!ok) begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic chk_reg(input logic [32:0] got, input logic [32:0] want); bump(got === want, "register"); endtask
    task automatic chk_ram(input logic [19:0] got, input logic [19:0] want); bump(got === want, "address"); endtask
    task automatic chk_time(input int got, input int want); bump(got >= want - 3 && got <= want + 3, "spacing"); endtask
    task automatic chk_duty(input int got, input int want); bump(got == want, "pwm level"); endtask
    // Request held from setup until pready is seen at an edge or 50 edges pass, released only then
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n = 0;
        @(posedge clk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 50);
        if (n >= 50) bump(1'b0, "no ready");
        r = prdata_out;
        e = pslverr_out;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_reg({e, r}, {xe, x});
    endtask
    // Format value 3 is refused, so the model keeps the old one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        if (msk[a[5:2]] != 0 && !(a == `OFS_PB_FORMAT && d[1:0] == 2'b11)) model[a[5:2]] = d & msk[a[5:2]];
    endtask
    task automatic wait_pb_end();
        logic [31:0] r;
        logic        e;
        int          n = 0;
        do begin repeat (100) @(posedge clk_in); apb(1'b0, `OFS_PB_TRIGGER, 32'h0, r, e); n++; end
        while (r !== 32'h0 && n < 400);
    endtask
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    initial begin
        logic [31:0] s;
        int          p, v;
        s = $urandom(87716);
        model = '{0, 0, 32'hFF, 0, 0, 32'h1F40, 0, 0, 0, 32'hFF, 0};
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 11; i++) rd(8'(4 * i), model[i], 1'b0);
        rd(8'h2C, 32'h0, 1'b1);
        for (int i = 0; i < 11; i++) if (msk[i] != 0) begin wr(8'(4 * i), $urandom); rd(8'(4 * i), model[i], 1'b0); end
        wr(`OFS_PB_FORMAT, 32'h3);
        rd(`OFS_PB_FORMAT, model[6], 1'b0);
        repeat (2100) @(posedge clk_in);
        chk_duty(level, 512);
        // Looping codes keep sounding, one-shots end; each new trigger replaces the last
        foreach (codes[k]) begin
            wr(`OFS_EFFECT_CODE, {16'h0, 8'($urandom), 8'(codes[k])});
            wr(`OFS_EFFECT_TRIGGER, 32'h1);
            rd(`OFS_EFFECT_TRIGGER, 32'h1, 1'b0);
            repeat (40) @(posedge clk_in);
            rd(`OFS_EFFECT_TRIGGER, {31'h0, codes[k] < 16}, 1'b0);
        end
        // Square starts low: -128 * 255 gives duty 2 at full synth volume
        wr(`OFS_SYNTH_VOLUME, 32'hFF);
        wr(`OFS_EFFECT_CODE, 32'h7710); wr(`OFS_EFFECT_TRIGGER, 32'h1);
        wr(`OFS_EFFECT_CODE, 32'h0301); wr(`OFS_EFFECT_TRIGGER, 32'h1);
        repeat (2100) @(posedge clk_in);
        chk_duty(level, 2);
        wr(`OFS_SYNTH_VOLUME, 32'h0);
        repeat (2100) @(posedge clk_in);
        rd(`OFS_EFFECT_TRIGGER, 32'h1, 1'b0);
        chk_duty(level, 512);
        wr(`OFS_EFFECT_TRIGGER, 32'h0);
        rd(`OFS_EFFECT_TRIGGER, 32'h1, 1'b0);
        wr(`OFS_EFFECT_CODE, 32'h0); wr(`OFS_EFFECT_TRIGGER, 32'h1);
        rd(`OFS_EFFECT_TRIGGER, 32'h0, 1'b0);
        // Each format over three bytes, muted so the pin stays centred
        wr(`OFS_PB_VOLUME, 32'h0);
        for (int f = 0; f < 3; f++) begin
            s = $urandom & 32'hFFFF0;
            v = 40000 + $urandom % 25536;
            p = 100000000 / v;
            wr(`OFS_PB_START, s); wr(`OFS_PB_LENGTH, 32'h3); wr(`OFS_PB_SAMPLE_RATE, v);
            wr(`OFS_PB_FORMAT, f); wr(`OFS_PB_REPEAT, 32'h0);
            for (int b = 0; b < 3; b++) exp_addr.push_back(s + b);
            gaps.delete();
            wr(`OFS_PB_TRIGGER, $urandom);
            rd(`OFS_PB_TRIGGER, 32'h1, 1'b0);
            rd(`OFS_PB_READ_POINTER, s, 1'b0);
            wait_pb_end();
            rd(`OFS_PB_TRIGGER, 32'h0, 1'b0);
            chk_reg(33'(exp_addr.size()), 33'h0);
            for (int g = 1; g < 3; g++) chk_time(gaps[g], (f == 2) ? 2 * p : p);
            chk_duty(level, 512);
        end
        // Repeat wraps to the start until the host stops it
        wr(`OFS_PB_LENGTH, 32'h2); wr(`OFS_PB_REPEAT, 32'h1); wr(`OFS_PB_FORMAT, 32'h0);
        for (int b = 0; b < 5; b++) exp_addr.push_back(s + b % 2);
        wr(`OFS_PB_TRIGGER, 32'h0);
        for (int n = 0; n < 20000 && exp_addr.size() != 0; n++) @(posedge clk_in);
        chk_reg(33'(exp_addr.size()), 33'h0);
        rd(`OFS_PB_READ_POINTER, s, 1'b0);
        rd(`OFS_PB_TRIGGER, 32'h1, 1'b0);
        wr(`OFS_PB_LENGTH, 32'h0); wr(`OFS_PB_TRIGGER, 32'h0);
        rd(`OFS_PB_TRIGGER, 32'h0, 1'b0);
        complete_run();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        #900000;
        bump(1'b0, "watchdog");
        complete_run();
    end
endmodule
